// ===== include/amp_pwm_pkg.sv
// Shared constants, types and lookup functions of the amplifier sequencer.
`default_nettype none
package amp_pwm_pkg;

	// ------------------------------------------------------------------
	// Register subaddresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_SYS_CTRL2 = 8'h05;
	localparam logic [7:0] ADDR_SOFT_PERIOD = 8'h1a;
	localparam logic [7:0] ADDR_OSC_TRIM = 8'h1b;
	localparam logic [7:0] ADDR_RECOVER = 8'h1c;
	localparam logic [7:0] ADDR_IN_ROUTE = 8'h20;
	localparam logic [7:0] ADDR_OUT_ROUTE = 8'h25;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int SHUTDOWN_BIT = 6;
	localparam logic SHUTDOWN_RST = 1'b1;
	localparam int SOFT_PERIOD_W = 5;
	localparam logic [4:0] SOFT_PERIOD_RST = 5'h0f;
	localparam int TRIM_RSVD_BIT = 7;
	localparam int TRIM_DONE_BIT = 6;
	localparam int TRIM_FACTORY_BIT = 1;
	localparam logic TRIM_FACTORY_RST = 1'b1;
	localparam int RECOVER_CODE_W = 4;
	localparam logic [3:0] RECOVER_CODE_RST = 4'h2;
	localparam logic [31:0] IN_ROUTE_RST = 32'h00017772;
	localparam logic [31:0] OUT_ROUTE_RST = 32'h01021003;
	localparam int CH1_MODE_BIT = 23;
	localparam int CH1_SRC_LSB = 20;
	localparam int CH2_MODE_BIT = 19;
	localparam int CH2_SRC_LSB = 16;
	localparam int OUT_A_LSB = 20;
	localparam int OUT_B_LSB = 16;
	localparam int OUT_C_LSB = 12;
	localparam int OUT_D_LSB = 8;

	// ------------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------------
	localparam logic [2:0] SRC_LEFT = 3'h0;
	localparam logic [2:0] SRC_RIGHT = 3'h1;
	localparam logic [2:0] SRC_ZERO = 3'h6;
	localparam logic [1:0] SOFT_NONE_TOP = 2'h0;

	typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_PLAY, ST_RECOVER} seq_state_t;

	// ------------------------------------------------------------------
	// Timing: times are held in tenths of a millisecond
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TENTH_MS_NS = 100000;
	localparam int TICK_CYCLES_DFLT = TENTH_MS_NS / CLK_PERIOD_NS;
	localparam int TRIM_CYCLES_DFLT = 1024;
	localparam int TIMER_W = 18;

	// Soft interval length per period code, tenths of a millisecond
	function automatic logic [TIMER_W-1:0] soft_tenths(
		input logic [4:0] code);
		unique case (code)
			5'h08: soft_tenths = 18'd165;
			5'h09: soft_tenths = 18'd239;
			5'h0a: soft_tenths = 18'd314;
			5'h0b: soft_tenths = 18'd404;
			5'h0c: soft_tenths = 18'd539;
			5'h0d: soft_tenths = 18'd703;
			5'h0e: soft_tenths = 18'd942;
			5'h0f: soft_tenths = 18'd1257;
			5'h10: soft_tenths = 18'd1646;
			5'h11: soft_tenths = 18'd2394;
			5'h12: soft_tenths = 18'd3142;
			5'h13: soft_tenths = 18'd4039;
			5'h14: soft_tenths = 18'd5386;
			5'h15: soft_tenths = 18'd7031;
			5'h16: soft_tenths = 18'd9425;
			5'h17: soft_tenths = 18'd12566;
			5'h18: soft_tenths = 18'd17281;
			5'h19: soft_tenths = 18'd25136;
			5'h1a: soft_tenths = 18'd32991;
			5'h1b: soft_tenths = 18'd42417;
			5'h1c: soft_tenths = 18'd56556;
			5'h1d: soft_tenths = 18'd73837;
			5'h1e: soft_tenths = 18'd98973;
			5'h1f: soft_tenths = 18'd131964;
			default: soft_tenths = 18'd0;
		endcase
	endfunction

	// Fault recovery wait per code, tenths of a millisecond
	function automatic logic [TIMER_W-1:0] recover_tenths(
		input logic [3:0] code);
		unique case (code)
			4'h3: recover_tenths = 18'd4490;
			4'h4: recover_tenths = 18'd5980;
			4'h5: recover_tenths = 18'd7480;
			4'h6: recover_tenths = 18'd8980;
			4'h7: recover_tenths = 18'd10470;
			4'h8: recover_tenths = 18'd11970;
			4'h9: recover_tenths = 18'd13460;
			4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: recover_tenths = 18'd14960;
			default: recover_tenths = 18'd2990;
		endcase
	endfunction

endpackage
`default_nettype wire

// ===== hdl/pwm_channel.sv
// One internal PWM channel: true leg and a second leg, complementary in two-level mode.
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
	import amp_pwm_pkg::*;
#(
	parameter int PWM_W = 8
) (
	input wire logic clk_sys, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [PWM_W-1:0] carrier, // Shared sawtooth carrier
	input wire logic [PWM_W-1:0] sample, // Signed sample, top bits
	input wire logic three_level, // 1: three-level, 0: two-level
	input wire logic force_half, // Hold 50% duty
	input wire logic halt, // Stop all switching
	output logic pwm_pos, // Channel leg
	output logic pwm_neg // Inverted leg in two-level, mirrored-duty leg in three-level
);

	// ------------------------------------------------------------------
	// Duty computation
	// ------------------------------------------------------------------
	localparam logic [PWM_W-1:0] HALF = {1'b1, {(PWM_W-1){1'b0}}};

	// Offset binary duty; 50% is the mid code
	wire [PWM_W-1:0] duty = force_half ? HALF :
		{~sample[PWM_W-1], sample[PWM_W-2:0]};
	// Mirrored duty drives the second leg in three-level mode
	wire [PWM_W-1:0] mirror = {PWM_W{1'b0}} - duty;
	wire pos_on = carrier < duty;
	wire neg_on = three_level ? (carrier < mirror) : !pos_on;

	// Registered legs keep the pins glitch free
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pwm_pos <= 1'b0;
			pwm_neg <= 1'b0;
		end else begin
			pwm_pos <= !halt && pos_on;
			pwm_neg <= !halt && neg_on;
		end
	end

endmodule
`default_nettype wire

// ===== hdl/amp_pwm_sequencer.sv
// Soft start/stop, trim, fault recovery and routing around a PWM modulator.
`timescale 1ns/1ps
`default_nettype none
module amp_pwm_sequencer
	import amp_pwm_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int PWM_W = 8,
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
	parameter int TRIM_CYCLES = TRIM_CYCLES_DFLT
) (
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic reg_wr_en, // Register write strobe
	input wire logic reg_rd_en, // Register read strobe
	input wire logic [7:0] reg_addr, // Register subaddress
	input wire logic [31:0] reg_wdata, // Write data
	output logic [31:0] reg_rdata, // Read data, held
	output logic reg_rd_valid, // Read data valid pulse
	input wire logic link_clk, // Serial audio link clock
	input wire logic [SAMPLE_W-1:0] slot_left, // Left slot sample
	input wire logic [SAMPLE_W-1:0] slot_right, // Right slot sample
	input wire logic slot_valid, // Sample pair valid, link clock
	input wire logic power_down_pin_n, // Power-down pin, low = down
	input wire logic backend_fault, // Power stage fault, high
	output logic stage_reset, // Power stage reset, high
	output logic factory_trim_sel, // Oscillator uses factory trim
	output logic output_pin_a, // PWM pin A
	output logic output_pin_b, // PWM pin B
	output logic output_pin_c, // PWM pin C
	output logic output_pin_d // PWM pin D
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam int TRIM_W = $clog2(TRIM_CYCLES + 1);

	generate
		if (PWM_W < 2 || PWM_W > SAMPLE_W) begin : g_bad_width
			$error("PWM_W must lie between 2 and SAMPLE_W");
		end
		if (TICK_CYCLES < 2 || TRIM_CYCLES < 1) begin : g_bad_count
			$error("TICK_CYCLES must be 2 or more, TRIM_CYCLES 1 or more");
		end
	endgenerate

	// ------------------------------------------------------------------
	// Link domain: capture the sample pair and flip a toggle
	// ------------------------------------------------------------------
	logic [SAMPLE_W-1:0] link_left_ff;
	logic [SAMPLE_W-1:0] link_right_ff;
	logic link_tgl_ff;

	// Held words stay stable for a whole frame, far longer than the sync
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_left_ff <= '0;
			link_right_ff <= '0;
			link_tgl_ff <= 1'b0;
		end else if (slot_valid) begin
			link_left_ff <= slot_left;
			link_right_ff <= slot_right;
			link_tgl_ff <= !link_tgl_ff;
		end
	end

	// ------------------------------------------------------------------
	// Synchronisers: toggle, fault and power-down pin
	// ------------------------------------------------------------------
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic tgl_seen_ff;

	// First stage is read only by the second stage
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
			tgl_seen_ff <= 1'b0;
		end else begin
			sync1_ff <= {power_down_pin_n, backend_fault, link_tgl_ff};
			sync2_ff <= sync1_ff;
			tgl_seen_ff <= sync2_ff[0];
		end
	end

	wire new_sample = sync2_ff[0] ^ tgl_seen_ff;
	wire fault_now = sync2_ff[1];
	wire pdn_up = sync2_ff[2];

	logic [SAMPLE_W-1:0] left_ff;
	logic [SAMPLE_W-1:0] right_ff;

	// Sample words are taken only after the toggle has settled
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			left_ff <= '0;
			right_ff <= '0;
		end else if (new_sample) begin
			left_ff <= link_left_ff;
			right_ff <= link_right_ff;
		end
	end

	// ------------------------------------------------------------------
	// Register write decode
	// ------------------------------------------------------------------
	wire wr_sys = reg_wr_en && reg_addr == ADDR_SYS_CTRL2;
	wire wr_soft = reg_wr_en && reg_addr == ADDR_SOFT_PERIOD;
	wire wr_trim = reg_wr_en && reg_addr == ADDR_OSC_TRIM;
	wire wr_rec = reg_wr_en && reg_addr == ADDR_RECOVER;
	wire wr_in = reg_wr_en && reg_addr == ADDR_IN_ROUTE;
	wire wr_out = reg_wr_en && reg_addr == ADDR_OUT_ROUTE;

	logic shutdown_ff;
	logic [4:0] soft_period_ff;
	logic [3:0] rec_code_ff;
	logic rec_locked_ff;
	logic [31:0] in_route_ff;
	logic [31:0] out_route_ff;

	// Plain control registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shutdown_ff <= SHUTDOWN_RST;
			soft_period_ff <= SOFT_PERIOD_RST;
			in_route_ff <= IN_ROUTE_RST;
			out_route_ff <= OUT_ROUTE_RST;
		end else begin
			if (wr_sys)
				shutdown_ff <= reg_wdata[SHUTDOWN_BIT];
			if (wr_soft)
				soft_period_ff <= reg_wdata[SOFT_PERIOD_W-1:0];
			if (wr_in)
				in_route_ff <= reg_wdata;
			if (wr_out)
				out_route_ff <= reg_wdata;
		end
	end

	// Recovery period locks after its first write
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rec_code_ff <= RECOVER_CODE_RST;
			rec_locked_ff <= 1'b0;
		end else if (wr_rec && !rec_locked_ff) begin
			rec_code_ff <= reg_wdata[RECOVER_CODE_W-1:0];
			rec_locked_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Oscillator trim: a write starts a run, done rises at its end
	// ------------------------------------------------------------------
	logic factory_dis_ff;
	logic trim_done_ff;
	logic trim_busy_ff;
	logic [TRIM_W-1:0] trim_cnt_ff;

	// Trim is never started by reset; the host must kick it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			factory_dis_ff <= TRIM_FACTORY_RST;
			trim_done_ff <= 1'b0;
			trim_busy_ff <= 1'b0;
			trim_cnt_ff <= '0;
		end else if (wr_trim) begin
			factory_dis_ff <= reg_wdata[TRIM_FACTORY_BIT];
			trim_done_ff <= 1'b0;
			trim_busy_ff <= 1'b1;
			trim_cnt_ff <= TRIM_W'(TRIM_CYCLES - 1);
		end else if (trim_busy_ff) begin
			if (trim_cnt_ff == '0) begin
				trim_busy_ff <= 1'b0;
				trim_done_ff <= 1'b1;
			end else begin
				trim_cnt_ff <= trim_cnt_ff - 1'b1;
			end
		end
	end

	assign factory_trim_sel = !factory_dis_ff;

	// ------------------------------------------------------------------
	// Tenth-millisecond tick from the local clock
	// ------------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt_ff;
	wire tick = tick_cnt_ff == TICK_W'(TICK_CYCLES - 1);

	// Free running; a started interval may lose up to one tick
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
	end

	// ------------------------------------------------------------------
	// Sequencer: off, soft interval, play, fault recovery
	// ------------------------------------------------------------------
	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [TIMER_W-1:0] timer_ff;
	logic [TIMER_W-1:0] nxt_timer;
	logic run_prev_ff;

	wire run_now = !shutdown_ff && pdn_up;
	wire run_change = run_now != run_prev_ff;
	wire soft_none = soft_period_ff[4:3] == SOFT_NONE_TOP;
	wire [TIMER_W-1:0] soft_len = soft_tenths(soft_period_ff);
	wire [TIMER_W-1:0] rec_len = recover_tenths(rec_code_ff);
	wire timer_zero = timer_ff == '0;
	wire [TIMER_W-1:0] timer_dec = (tick && !timer_zero) ?
		timer_ff - 1'b1 : timer_ff;
	wire seq_target_play = run_now;

	// Fault wins over a run change; the stage must be safe first
	always_comb begin
		nxt_state = state_ff;
		nxt_timer = timer_dec;
		if (state_ff != ST_RECOVER && fault_now) begin
			nxt_state = ST_RECOVER;
			nxt_timer = rec_len;
		end else if (state_ff != ST_RECOVER && run_change) begin
			if (soft_none) begin
				nxt_state = seq_target_play ? ST_PLAY : ST_OFF;
			end else begin
				nxt_state = ST_SOFT;
				nxt_timer = soft_len;
			end
		end else begin
			unique case (state_ff)
				ST_SOFT: begin
					if (timer_zero)
						nxt_state = seq_target_play ? ST_PLAY : ST_OFF;
				end
				ST_RECOVER: begin
					if (timer_zero)
						nxt_state = seq_target_play ? ST_PLAY : ST_OFF;
				end
				ST_OFF, ST_PLAY: begin
					nxt_state = state_ff;
				end
			endcase
		end
	end

	// State, timer and the registered stage reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_OFF;
			timer_ff <= '0;
			run_prev_ff <= 1'b0;
			stage_reset <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			run_prev_ff <= run_now;
			stage_reset <= nxt_state == ST_RECOVER;
		end
	end

	wire halt = state_ff == ST_OFF || state_ff == ST_RECOVER;
	wire force_half = state_ff == ST_SOFT;

	// ------------------------------------------------------------------
	// Input routing and modulation choice
	// ------------------------------------------------------------------
	wire [2:0] ch1_src = in_route_ff[CH1_SRC_LSB +: 3];
	wire [2:0] ch2_src = in_route_ff[CH2_SRC_LSB +: 3];
	// Reserved source codes feed silence rather than stale data
	wire [SAMPLE_W-1:0] ch1_sample = ch1_src == SRC_LEFT ? left_ff :
		ch1_src == SRC_RIGHT ? right_ff : '0;
	wire [SAMPLE_W-1:0] ch2_sample = ch2_src == SRC_LEFT ? left_ff :
		ch2_src == SRC_RIGHT ? right_ff : '0;
	wire ch1_three = in_route_ff[CH1_MODE_BIT];
	wire ch2_three = in_route_ff[CH2_MODE_BIT];

	logic [PWM_W-1:0] carrier_ff;

	// Shared carrier keeps both channels in phase
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			carrier_ff <= '0;
		else
			carrier_ff <= carrier_ff + 1'b1;
	end

	logic [3:0] chan;

	pwm_channel #(.PWM_W(PWM_W)) u_ch1 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.carrier(carrier_ff),
		.sample(ch1_sample[SAMPLE_W-1 -: PWM_W]),
		.three_level(ch1_three),
		.force_half(force_half),
		.halt(halt),
		.pwm_pos(chan[0]),
		.pwm_neg(chan[2])
	);

	pwm_channel #(.PWM_W(PWM_W)) u_ch2 (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.carrier(carrier_ff),
		.sample(ch2_sample[SAMPLE_W-1 -: PWM_W]),
		.three_level(ch2_three),
		.force_half(force_half),
		.halt(halt),
		.pwm_pos(chan[1]),
		.pwm_neg(chan[3])
	);

	// ------------------------------------------------------------------
	// Output mux: index 0 ch1, 1 ch2, 2 ch1 second leg, 3 ch2 second leg (inverted in two-level)
	// ------------------------------------------------------------------
	wire [1:0] sel_a = out_route_ff[OUT_A_LSB +: 2];
	wire [1:0] sel_b = out_route_ff[OUT_B_LSB +: 2];
	wire [1:0] sel_c = out_route_ff[OUT_C_LSB +: 2];
	wire [1:0] sel_d = out_route_ff[OUT_D_LSB +: 2];

	// Pins are registered after the mux to avoid select glitches
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			output_pin_a <= 1'b0;
			output_pin_b <= 1'b0;
			output_pin_c <= 1'b0;
			output_pin_d <= 1'b0;
		end else begin
			output_pin_a <= chan[sel_a];
			output_pin_b <= chan[sel_b];
			output_pin_c <= chan[sel_c];
			output_pin_d <= chan[sel_d];
		end
	end

	// ------------------------------------------------------------------
	// Register readback
	// ------------------------------------------------------------------
	wire [7:0] sys_rd = 8'(32'(shutdown_ff) << SHUTDOWN_BIT);
	wire [7:0] trim_rd = 8'((32'h1 << TRIM_RSVD_BIT)
		| (32'(trim_done_ff) << TRIM_DONE_BIT)
		| (32'(factory_dis_ff) << TRIM_FACTORY_BIT));
	// Unmapped subaddresses read as zero
	wire [31:0] rd_mux =
		reg_addr == ADDR_SYS_CTRL2 ? {24'h0, sys_rd} :
		reg_addr == ADDR_SOFT_PERIOD ? {27'h0, soft_period_ff} :
		reg_addr == ADDR_OSC_TRIM ? {24'h0, trim_rd} :
		reg_addr == ADDR_RECOVER ? {28'h0, rec_code_ff} :
		reg_addr == ADDR_IN_ROUTE ? in_route_ff :
		reg_addr == ADDR_OUT_ROUTE ? out_route_ff : 32'h0;

	// Read data holds until the next read
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en)
				reg_rdata <= rd_mux;
		end
	end

endmodule
`default_nettype wire

// ===== verif/amp_pwm_props.sv
// Port-level assertions for the amplifier sequencer.
`timescale 1ns/1ps
`default_nettype none
module amp_pwm_props
	import amp_pwm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
	input wire logic clk_sys, // Clock
	input wire logic arst_n, // Reset
	input wire logic reg_wr_en, // Write
	input wire logic reg_rd_en, // Read
	input wire logic [7:0] reg_addr, // Address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic reg_rd_valid, // Read valid
	input wire logic backend_fault, // Stage fault
	input wire logic stage_reset, // Stage reset
	input wire logic factory_trim_sel, // Trim select
	input wire logic output_pin_a, // Pin A
	input wire logic output_pin_b, // Pin B
	input wire logic output_pin_c, // Pin C
	input wire logic output_pin_d // Pin D
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [31:0] rec_cnt_ff;
	// Address decode and pin summary
	wire logic trim_acc = reg_addr == ADDR_OSC_TRIM;
	wire logic mapped = reg_addr inside {ADDR_SYS_CTRL2, ADDR_SOFT_PERIOD,
		ADDR_OSC_TRIM, ADDR_RECOVER, ADDR_IN_ROUTE, ADDR_OUT_ROUTE};
	wire logic pins_low = !(output_pin_a | output_pin_b | output_pin_c |
		output_pin_d);
	// Length of the running recovery wait, too long for a repetition
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rec_cnt_ff <= 32'h0;
		end else if (stage_reset) begin
			rec_cnt_ff <= rec_cnt_ff + 32'h1;
		end else begin
			rec_cnt_ff <= 32'h0;
		end
	end
	a_rd_valid_pulse: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read strobe got no valid");
	a_rd_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
		else $error("valid without a read");
	a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rdata == 0)
		else $error("unmapped read not zero");
	a_trim_sel_follow: assert property (reg_wr_en && trim_acc |=>
		factory_trim_sel == !$past(reg_wdata[TRIM_FACTORY_BIT]))
		else $error("trim select wrong");
	a_trim_not_done: assert property ((reg_wr_en && trim_acc) ##2
		(reg_rd_en && trim_acc) |=> !reg_rdata[TRIM_DONE_BIT])
		else $error("trim done too early");
	a_trim_fixed_bits: assert property (reg_rd_en && trim_acc |=>
		reg_rdata[31:7] == 25'h1 && reg_rdata[5:2] == 4'h0 && !reg_rdata[0])
		else $error("trim fixed bits wrong");
	a_fault_halts_pins: assert property (stage_reset [*3] |-> pins_low)
		else $error("pins active in recovery");
	a_fault_enters: assert property (backend_fault [*3] |-> ##[0:3] stage_reset)
		else $error("fault not taken");
	a_recover_min: assert property ($fell(stage_reset) |->
		rec_cnt_ff >= 2989 * TICK_CYCLES)
		else $error("recovery too short");
	a_recover_max: assert property (stage_reset |->
		rec_cnt_ff <= 14960 * TICK_CYCLES + 2)
		else $error("recovery too long");
	c_recovery: cover property (stage_reset [*3]);
	c_trim_write: cover property (reg_wr_en && trim_acc);
	c_unmapped: cover property (reg_rd_en && !mapped);
endmodule
`default_nettype wire

// ===== verif/audio_slot_source.sv
// Serial audio source model: one sample pair every 16 link cycles.
`timescale 1ns/1ps
`default_nettype none
module audio_slot_source (
	input wire logic link_clk, // Link clock
	input wire logic arst_n, // Reset
	input wire logic [15:0] left_in, // Left value
	input wire logic [15:0] right_in, // Right value
	output logic [15:0] slot_left, // Left slot
	output logic [15:0] slot_right, // Right slot
	output logic slot_valid // Pair strobe
);
	logic [3:0] cnt_ff;
	// Between pairs the data flips, so stale data never looks fresh
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 4'h0;
			slot_valid <= 1'b0;
			slot_left <= 16'h0;
			slot_right <= 16'h0;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
			slot_valid <= cnt_ff == 4'h0;
			slot_left <= (cnt_ff == 4'h0) ? left_in : ~slot_left;
			slot_right <= (cnt_ff == 4'h0) ? right_in : ~slot_right;
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the amplifier sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import amp_pwm_pkg::*;
	localparam int TICK = 2;
	logic clk_sys = 0;
	logic link_clk = 0;
	logic arst_n = 0;
	logic reg_wr_en = 0;
	logic reg_rd_en = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_rd_valid, slot_valid, stage_reset, factory_trim_sel;
	logic [15:0] slot_left, slot_right;
	logic power_down_pin_n = 1;
	logic backend_fault = 0;
	logic output_pin_a, output_pin_b, output_pin_c, output_pin_d;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	amp_pwm_sequencer #(.TICK_CYCLES(TICK), .TRIM_CYCLES(4)) i_dut (.*);
	audio_slot_source i_src (.left_in(16'h4000), .right_in(16'hc000), .*);
	// Clocks, the link one off in phase
	initial forever #5 clk_sys = ~clk_sys;
	initial begin
		#3;
		forever #6 link_clk = ~link_clk;
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		tick(1);
		reg_wr_en = 1;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr_en = 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		tick(1);
		reg_rd_en = 1;
		reg_addr = a;
		tick(1);
		reg_rd_en = 0;
		cmp(reg_rd_valid, 1);
		cmp(reg_rdata, exp);
	endtask
	// High cycles of each pin, and of A&C and B&D, over one carrier period
	task automatic duty(input logic [31:0] ea, eb, ec, ed, eac, ebd);
		logic [31:0] n [6];
		n = '{default: 32'h0};
		repeat (256) begin
			tick(1);
			n[0] += 32'(output_pin_a);
			n[1] += 32'(output_pin_b);
			n[2] += 32'(output_pin_c);
			n[3] += 32'(output_pin_d);
			n[4] += 32'(output_pin_a & output_pin_c);
			n[5] += 32'(output_pin_b & output_pin_d);
		end
		cmp(n[0], ea);
		cmp(n[1], eb);
		cmp(n[2], ec);
		cmp(n[3], ed);
		cmp(n[4], eac);
		cmp(n[5], ebd);
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		rdc(ADDR_SYS_CTRL2, 32'h40);
		rdc(ADDR_SOFT_PERIOD, 32'h0f);
		rdc(ADDR_OSC_TRIM, 32'h82);
		rdc(ADDR_RECOVER, 32'h02);
		rdc(ADDR_IN_ROUTE, 32'h00017772);
		rdc(ADDR_OUT_ROUTE, 32'h01021003);
		rdc(8'h30, 32'h0);
		cmp(factory_trim_sel, 0);
	endtask
	task automatic t_trim();
		wr(ADDR_OSC_TRIM, 32'h00);
		cmp(factory_trim_sel, 1);
		rdc(ADDR_OSC_TRIM, 32'h80);
		tick(8);
		rdc(ADDR_OSC_TRIM, 32'hc0);
		wr(ADDR_OSC_TRIM, 32'h02);
		cmp(factory_trim_sel, 0);
		tick(8);
		rdc(ADDR_OSC_TRIM, 32'hc2);
	endtask
	task automatic t_recover_reg();
		wr(ADDR_RECOVER, 32'h03);
		wr(ADDR_RECOVER, 32'h0a);
		rdc(ADDR_RECOVER, 32'h03);
	endtask
	// Soft start by register, soft stop and restart by the pin
	task automatic t_soft();
		wr(ADDR_SOFT_PERIOD, 32'h08);
		wr(ADDR_SYS_CTRL2, 32'h00);
		tick(8);
		duty(128, 128, 128, 128, 128, 0);
		tick(100);
		duty(192, 64, 64, 192, 64, 0);
		power_down_pin_n = 0;
		tick(8);
		duty(128, 128, 128, 128, 128, 0);
		tick(100);
		duty(0, 0, 0, 0, 0, 0);
		wr(ADDR_SOFT_PERIOD, 32'h00);
		power_down_pin_n = 1;
		tick(8);
		duty(192, 64, 64, 192, 64, 0);
	endtask
	// Reserved bits of the input routing keep their defaults
	task automatic route(input logic [7:0] f, input logic [31:0] ea, eb, ec,
		ed, eac, ebd);
		wr(ADDR_IN_ROUTE, {8'h00, f, 16'h7772});
		tick(300);
		duty(ea, eb, ec, ed, eac, ebd);
	endtask
	task automatic t_route();
		wr(ADDR_OUT_ROUTE, 32'h01012303);
		tick(8);
		duty(192, 64, 64, 192, 0, 0);
		route(8'h11, 64, 64, 192, 192, 0, 0);
		route(8'h61, 128, 64, 128, 192, 0, 0);
		route(8'h10, 64, 192, 192, 64, 0, 0);
		route(8'h16, 64, 128, 192, 128, 0, 0);
		route(8'h81, 192, 64, 64, 192, 64, 0);
		route(8'h09, 192, 64, 64, 192, 0, 64);
		route(8'h01, 192, 64, 64, 192, 0, 0);
		wr(ADDR_OUT_ROUTE, 32'h01021003);
	endtask
	task automatic t_fault();
		logic [31:0] len, act;
		len = 0;
		act = 0;
		backend_fault = 1;
		while (stage_reset !== 1 && len < 10) begin
			tick(1);
			len++;
		end
		backend_fault = 0;
		len = 0;
		while (stage_reset === 1 && len < 20000) begin
			// Pins settle two cycles after the stage reset rises
			if (len >= 2)
				act += 32'(output_pin_a | output_pin_b |
					output_pin_c | output_pin_d);
			tick(1);
			len++;
		end
		cmp(act, 0);
		cmp(32'(len >= 8978 && len <= 8982), 1);
		tick(8);
		duty(192, 64, 64, 192, 64, 0);
	endtask
	task automatic t_shut();
		wr(ADDR_SYS_CTRL2, 32'h40);
		tick(8);
		duty(0, 0, 0, 0, 0, 0);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		arst_n = 1;
		t_reset();
		t_trim();
		t_recover_reg();
		t_soft();
		t_route();
		t_fault();
		t_shut();
		final_report();
	end
endmodule
bind amp_pwm_sequencer amp_pwm_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.*);
`default_nettype wire
